// file: bench/ssmo_host.sv
`timescale 1ns/10ps
// ==========================================================
// Host controller model: run and select pins plus motion feedback
module ssmo_host
	import ssmo_pkg::*;
(
	input wire logic mclk,
	output ssmo_pins_s pins,
	output logic torque_mode,
	output logic signed [15:0] cmd_speed,
	output logic signed [15:0] act_speed,
	output logic signed [31:0] dev_user,
	output logic signed [31:0] dev_pulse,
	output logic signed [15:0] torque_cmd
);
	// Quiet machine at power-up: no run, no motion, no deviation
	initial begin
		pins = '0;
		torque_mode = 1'b0;
		cmd_speed = '0;
		act_speed = '0;
		dev_user = '0;
		dev_pulse = '0;
		torque_cmd = '0;
	end

	// New pin levels and feedback land just after a rising edge
	task automatic drive(input ssmo_pins_s p, input logic signed [15:0] c,
		input logic signed [15:0] a, input logic signed [31:0] du,
		input logic signed [31:0] dp, input logic signed [15:0] t);
		@(posedge mclk);
		pins <= p;
		cmd_speed <= c;
		act_speed <= a;
		dev_user <= du;
		dev_pulse <= dp;
		torque_cmd <= t;
	endtask

	// Switch between torque control and position or speed control
	task automatic set_mode(input logic m);
		@(posedge mclk);
		torque_mode <= m;
	endtask
endmodule

// file: bench/ssmo_status_test.sv
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
	$display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module ssmo_status_test
	import ssmo_pkg::*;
;
	typedef struct packed {
		ssmo_pins_s p;
		logic unit;
		logic signed [15:0] cmd;
		logic signed [15:0] act;
		logic signed [31:0] du;
		logic signed [31:0] dp;
		logic signed [15:0] tq;
		ssmo_status_s st;
	} ssmo_row_s;
	logic mclk;
	logic rstn;
	ssmo_apb_req_s req;
	ssmo_apb_rsp_s rsp;
	ssmo_pins_s pins;
	logic tmode;
	logic signed [15:0] cmd, act, tq, sref, tref;
	logic signed [31:0] du, dp, mon;
	ssmo_status_s st;
	ssmo_tune_s tn;
	ssmo_row_s rows[8];
	int n_mismatch = 0;
	int n_checks = 0;
	logic [31:0] rd;
	logic er;
	int n;

	ssmo_host host(.mclk(mclk), .pins(pins), .torque_mode(tmode), .cmd_speed(cmd),
		.act_speed(act), .dev_user(du), .dev_pulse(dp), .torque_cmd(tq));
	ssmo_status #(.MS_CNT(10)) DUT(.mclk(mclk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp),
		.pins_raw(pins), .torque_mode(tmode), .cmd_speed(cmd), .act_speed(act),
		.dev_user(du), .dev_pulse(dp), .torque_cmd(tq), .status(st), .dev_monitor(mon),
		.speed_ref(sref), .torque_ref(tref), .tune(tn));

	// ==========================================================
	// Clock and watchdog
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		n_mismatch++;
		final_report();
	end

	// ==========================================================
	// Helpers
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// One APB transfer, held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge mclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge mclk);
		req.penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (rsp.pready !== 1'b1);
		r = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
	endtask
	// Torque after limiting: clipped only while both selects are off
	function automatic logic signed [15:0] exp_tq(input ssmo_row_s r);
		if (r.p.tq_sel != 2'h0) return r.tq;
		if (r.tq > 16'sh012C) return 16'sh012C;
		if (r.tq < 16'shFED4) return 16'shFED4;
		return r.tq;
	endfunction
	task automatic settle(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		rstn = 1'b0;
		req = '0;
		rows[0] = '{8'h80, 1'b0, 16'h03E8, 16'h041A, 32'h00000064, 32'h00000384, 16'h0190, 4'hA};
		rows[1] = '{8'h80, 1'b0, 16'h03E8, 16'h041B, 32'h00000065, 32'h00000000, 16'hFE70, 4'h0};
		rows[2] = '{8'h00, 1'b0, 16'h0000, 16'h0000, 32'hFFFFFF9C, 32'h00000000, 16'h0190, 4'h7};
		rows[3] = '{8'h00, 1'b1, 16'h0000, 16'hFFCE, 32'h00000000, 32'h00000065, 16'h0000, 4'h4};
		rows[4] = '{8'h90, 1'b1, 16'h0000, 16'h0033, 32'h00000000, 32'h00000005, 16'h0190, 4'h2};
		rows[5] = '{8'h80, 1'b0, 16'h1770, 16'h1388, 32'h00000000, 32'h00000000, 16'h0000, 4'h2};
		rows[6] = '{8'h82, 1'b0, 16'h1770, 16'h1770, 32'h00000000, 32'h00000000, 16'h0000, 4'hA};
		rows[7] = '{8'h81, 1'b0, 16'h03E8, 16'h03E8, 32'h00000000, 32'h00000000, 16'h0000, 4'h2};
		settle(1);
		`CHK(st, 4'h0)
		settle(1);
		rstn = 1'b1;
		settle(3);
		`CHK({tn.fwd_en, tn.rev_en, tn.stroke, tn.dwell_ms}, {2'h3, 15'h00C8, 13'h05DC})
		$display("test reset done");
		// Register defaults, clamping and an unmapped address
		apb(1'b0, OFS_COINC, '0, rd, er);
		`CHK(rd, RST_COINC)
		apb(1'b0, OFS_DEV_RANGE, '0, rd, er);
		`CHK(rd, RST_DEV_RANGE)
		apb(1'b0, OFS_MIN_OFF, '0, rd, er);
		`CHK(rd, RST_MIN_OFF)
		apb(1'b1, OFS_MIN_OFF, 32'h000007D0, rd, er);
		apb(1'b0, OFS_MIN_OFF, '0, rd, er);
		`CHK(rd, MAX_MS_SET)
		apb(1'b1, OFS_MIN_OFF, RST_MIN_OFF, rd, er);
		apb(1'b1, OFS_FWD_TQ, 32'h00000190, rd, er);
		apb(1'b0, OFS_FWD_TQ, '0, rd, er);
		`CHK(rd, MAX_TQ)
		apb(1'b1, OFS_STROKE, 32'h00004E21, rd, er);
		apb(1'b0, OFS_STROKE, '0, rd, er);
		`CHK({rd, tn.stroke}, {MAX_STROKE, 15'h4E20})
		apb(1'b0, 12'h040, '0, rd, er);
		`CHK({er, rd}, {1'b1, 32'h00000000})
		for (int d = 0; d < 4; d++) begin
			apb(1'b1, OFS_DIR, 32'(d), rd, er);
			settle(3);
			`CHK({tn.fwd_en, tn.rev_en}, (d == 0) ? 2'h3 : (d == 1) ? 2'h2 : 2'h1)
		end
		$display("test registers done");
		// Table of status and limiting cases
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, OFS_DEV_UNIT, {31'h0, rows[i].unit}, rd, er);
			host.drive(rows[i].p, rows[i].cmd, rows[i].act, rows[i].du, rows[i].dp, rows[i].tq);
			settle(400);
			`CHK(st, rows[i].st)
			`CHK(mon, rows[i].unit ? rows[i].dp : rows[i].du)
			`CHK(sref, (rows[i].cmd > 16'sh1388 && !rows[i].p.pulse_train) ? 16'sh1388 : rows[i].cmd)
			`CHK(tref, exp_tq(rows[i]))
		end
		// Torque control uses its own maximum speed
		apb(1'b1, OFS_MAX_TQ, 32'h00000064, rd, er);
		host.set_mode(1'b1);
		host.drive(8'h80, 16'sh00C8, 16'sh0064, '0, '0, '0);
		settle(400);
		`CHK(sref, 16'sh0064)
		`CHK(st.speed_match, 1'b0)
		host.set_mode(1'b0);
		$display("test table done");
		// Judgment time of 5 ms delays recognition
		apb(1'b1, OFS_DEV_UNIT, '0, rd, er);
		apb(1'b1, OFS_JUDGE, 32'h00000005, rd, er);
		host.drive(8'h00, '0, '0, 32'h000001F4, '0, '0);
		settle(400);
		host.drive(8'h00, '0, '0, '0, '0, '0);
		n = 0;
		while (st.zero_deviation !== 1'b1 && n < 300) begin
			settle(1);
			n++;
		end
		n = 0;
		while (st.in_position !== 1'b1 && n < 300) begin
			settle(1);
			n++;
		end
		`CHK(n >= 50 && n <= 60, 1'b1)
		$display("test judgment done");
		// Homing waits for pending pulses to drain
		host.drive(8'h00, '0, '0, 32'h000001F4, '0, '0);
		settle(400);
		host.drive(8'h08, '0, '0, '0, '0, '0);
		settle(400);
		`CHK(st.in_position, 1'b0)
		host.drive(8'h0C, '0, '0, '0, '0, '0);
		settle(400);
		`CHK(st.in_position, 1'b1)
		$display("test homing done");
		// Single shot applies only after reload, pulse lasts the on time
		host.drive(8'h00, '0, '0, 32'h000001F4, '0, '0);
		settle(400);
		apb(1'b1, OFS_FMT, 32'h00000001, rd, er);
		apb(1'b0, OFS_STATUS, '0, rd, er);
		`CHK(rd[4], 1'b0)
		apb(1'b1, OFS_RELOAD, 32'h00000001, rd, er);
		apb(1'b0, OFS_STATUS, '0, rd, er);
		`CHK(rd[4], 1'b1)
		apb(1'b1, OFS_MIN_OFF, 32'h00000001, rd, er);
		host.drive(8'h00, '0, '0, '0, '0, '0);
		n = 0;
		while (st.in_position !== 1'b1 && n < 300) begin
			settle(1);
			n++;
		end
		n = 0;
		while (st.in_position === 1'b1 && n < 50) begin
			settle(1);
			n++;
		end
		`CHK(n, 10)
		settle(300);
		`CHK(st.in_position, 1'b0)
		$display("test single shot done");
		final_report();
	end
endmodule

// file: rtl/ssmo_pkg.sv
package ssmo_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CTRL_CYCLE_NS = 1000;
	localparam int CTRL_CYCLES = (CTRL_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

	// ==========================================================
	// Register byte offsets
	localparam logic [11:0] OFS_COINC = 12'h000;
	localparam logic [11:0] OFS_ZSPD = 12'h004;
	localparam logic [11:0] OFS_DEV_UNIT = 12'h008;
	localparam logic [11:0] OFS_DEV_RANGE = 12'h00C;
	localparam logic [11:0] OFS_FMT = 12'h010;
	localparam logic [11:0] OFS_MIN_OFF = 12'h014;
	localparam logic [11:0] OFS_JUDGE = 12'h018;
	localparam logic [11:0] OFS_MAX_PS = 12'h01C;
	localparam logic [11:0] OFS_MAX_TQ = 12'h020;
	localparam logic [11:0] OFS_FWD_TQ = 12'h024;
	localparam logic [11:0] OFS_REV_TQ = 12'h028;
	localparam logic [11:0] OFS_STROKE = 12'h02C;
	localparam logic [11:0] OFS_DWELL = 12'h030;
	localparam logic [11:0] OFS_DIR = 12'h034;
	localparam logic [11:0] OFS_STATUS = 12'h038;
	localparam logic [11:0] OFS_RELOAD = 12'h03C;

	// ==========================================================
	// Reset values and setting ranges
	localparam logic [31:0] RST_COINC = 32'h00000032;
	localparam logic [31:0] RST_ZSPD = 32'h00000032;
	localparam logic [31:0] RST_DEV_RANGE = 32'h00000064;
	localparam logic [31:0] RST_MIN_OFF = 32'h00000014;
	localparam logic [31:0] RST_JUDGE = 32'h00000000;
	localparam logic [31:0] RST_MAX_SPD = 32'h00001388;
	localparam logic [31:0] RST_TQ = 32'h0000012C;
	localparam logic [31:0] RST_STROKE = 32'h000000C8;
	localparam logic [31:0] RST_DWELL = 32'h000005DC;
	localparam logic [31:0] MIN_RANGE_SPD = 32'h0000000A;
	localparam logic [31:0] MAX_SPD_CAP = 32'h00001388;
	localparam logic [31:0] MAX_DEV_RANGE = 32'h00030D40;
	localparam logic [31:0] MAX_MS_SET = 32'h000003E8;
	localparam logic [31:0] MAX_TQ = 32'h0000012C;
	localparam logic [31:0] MAX_STROKE = 32'h00004E20;
	localparam logic [31:0] MAX_DWELL = 32'h00001388;
	localparam logic [31:0] MAX_DIR = 32'h00000002;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {SSMO_DIR_ALT, SSMO_DIR_FWD, SSMO_DIR_REV} ssmo_dir_e;
	typedef enum logic [1:0] {SSMO_OUT_IDLE, SSMO_OUT_ON, SSMO_OUT_OFF} ssmo_out_e;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} ssmo_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ssmo_apb_rsp_s;

	typedef struct packed {
		logic fwd_run;
		logic rev_run;
		logic [1:0] tq_sel;
		logic homing;
		logic drained;
		logic pulse_train;
		logic override;
	} ssmo_pins_s;

	typedef struct packed {
		logic speed_match;
		logic zero_speed;
		logic zero_deviation;
		logic in_position;
	} ssmo_status_s;

	typedef struct packed {
		logic fwd_en;
		logic rev_en;
		logic [14:0] stroke;
		logic [12:0] dwell_ms;
	} ssmo_tune_s;

	typedef struct packed {
		logic [15:0] coinc;
		logic [15:0] zspd;
		logic dev_unit;
		logic [17:0] dev_range;
		logic fmt;
		logic [9:0] min_off;
		logic [9:0] judge;
		logic [15:0] max_ps;
		logic [15:0] max_tq;
		logic [8:0] fwd_tq;
		logic [8:0] rev_tq;
		logic [14:0] stroke;
		logic [12:0] dwell;
		ssmo_dir_e dir;
	} ssmo_cfg_s;

endpackage

// file: rtl/ssmo_status.sv
`timescale 1ns/10ps
// Behaviour
// - speed_match high while actual speed within coincidence range of command
// - speed_match low when command is clipped by max speed or override
// - speed_match held low while both run inputs are off
// - zero_speed high while absolute speed within zero speed range
// - Unit select 0 picks user-unit deviation, 1 picks encoder-pulse deviation
// - Selected unit also feeds the deviation monitor output
// - zero_deviation high while absolute deviation within deviation range
// - In-position needs zero deviation and zero speed together
// - During homing, pending pulses must be drained too
// - Deviation range compared in the selected unit
// - Format 0 level, 1 single shot; new format applies only after writing 1 to the reload register
// - Min off / shot on time held, 1 to 1000 ms, default 20
// - Torque clipped to forward and reverse limits when limit selects off
// - Speed clipped to max speed except in pulse-train operation
// - Tuning direction 0 alternate, 1 forward only, 2 reverse only
// - Tuning stroke and dwell settings held within their ranges
// - Single shot output lasts exactly the programmed on time
// - In-position recognised only after condition held for judgment time
module ssmo_status
	import ssmo_pkg::*;
#(
	parameter int MS_CNT = ssmo_pkg::MS_CYCLES
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire ssmo_apb_req_s apb_req,
	output ssmo_apb_rsp_s apb_rsp,
	input wire ssmo_pins_s pins_raw,
	input wire logic torque_mode,
	input wire logic signed [15:0] cmd_speed,
	input wire logic signed [15:0] act_speed,
	input wire logic signed [31:0] dev_user,
	input wire logic signed [31:0] dev_pulse,
	input wire logic signed [15:0] torque_cmd,
	output ssmo_status_s status,
	output logic signed [31:0] dev_monitor,
	output logic signed [15:0] speed_ref,
	output logic signed [15:0] torque_ref,
	output ssmo_tune_s tune
);

	localparam int PW = $clog2(MS_CNT + 1);
	localparam int CW = $clog2(CTRL_CYCLES + 1);

	// ==========================================================
	// Elaboration checks
	if (MS_CNT < 1) begin : g_bad_ms
		$error("MS_CNT must be at least one");
	end
	if (CTRL_CYCLES < 1) begin : g_bad_ctrl
		$error("control cycle must be at least one clock");
	end

	typedef struct packed {
		ssmo_cfg_s cfg;
		logic fmt_eff;
		logic ack;
		logic [31:0] prdata;
		logic pslverr;
		logic [CW-1:0] ccnt;
		ssmo_status_s stat;
		logic clamped;
		logic cond;
		logic qual;
		logic qual_d;
		logic [9:0] jcnt;
		logic [PW-1:0] jpre;
		ssmo_out_e ost;
		logic [9:0] ocnt;
		logic [PW-1:0] opre;
		logic signed [31:0] dev_mon;
		logic signed [15:0] spd;
		logic signed [15:0] tq;
		ssmo_tune_s tune;
	} ssmo_state_s;

	ssmo_state_s st;
	ssmo_state_s next_st;
	ssmo_pins_s pins;
	logic [$bits(ssmo_pins_s)-1:0] pins_q;
	logic tick;
	logic hit;
	logic [31:0] rd;
	logic signed [15:0] lim;
	logic [15:0] vmax;
	logic [32:0] dabs;
	logic zs;
	logic zd;
	logic ms_o;

	// ==========================================================
	// Helpers
	function automatic logic [32:0] abs33(input logic signed [32:0] v);
		abs33 = v[32] ? 33'(-v) : 33'(v);
	endfunction

	function automatic logic [31:0] uclamp(input logic [31:0] v, input logic [31:0] lo,
		input logic [31:0] hi);
		uclamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic signed [16:0] sclamp(input logic signed [16:0] v,
		input logic signed [16:0] lo, input logic signed [16:0] hi);
		sclamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// ==========================================================
	// Pin synchronisers
	ssmo_sync #(.W($bits(ssmo_pins_s))) u_sync (
		.mclk(mclk),
		.rstn(rstn),
		.d(pins_raw),
		.q(pins_q)
	);
	assign pins = ssmo_pins_s'(pins_q);

	// ==========================================================
	// Read decode
	always_comb begin
		hit = 1'b1;
		rd = 32'h00000000;
		if (apb_req.paddr == OFS_COINC) begin
			rd = 32'(st.cfg.coinc);
		end else if (apb_req.paddr == OFS_ZSPD) begin
			rd = 32'(st.cfg.zspd);
		end else if (apb_req.paddr == OFS_DEV_UNIT) begin
			rd = 32'(st.cfg.dev_unit);
		end else if (apb_req.paddr == OFS_DEV_RANGE) begin
			rd = 32'(st.cfg.dev_range);
		end else if (apb_req.paddr == OFS_FMT) begin
			rd = 32'(st.cfg.fmt);
		end else if (apb_req.paddr == OFS_MIN_OFF) begin
			rd = 32'(st.cfg.min_off);
		end else if (apb_req.paddr == OFS_JUDGE) begin
			rd = 32'(st.cfg.judge);
		end else if (apb_req.paddr == OFS_MAX_PS) begin
			rd = 32'(st.cfg.max_ps);
		end else if (apb_req.paddr == OFS_MAX_TQ) begin
			rd = 32'(st.cfg.max_tq);
		end else if (apb_req.paddr == OFS_FWD_TQ) begin
			rd = 32'(st.cfg.fwd_tq);
		end else if (apb_req.paddr == OFS_REV_TQ) begin
			rd = 32'(st.cfg.rev_tq);
		end else if (apb_req.paddr == OFS_STROKE) begin
			rd = 32'(st.cfg.stroke);
		end else if (apb_req.paddr == OFS_DWELL) begin
			rd = 32'(st.cfg.dwell);
		end else if (apb_req.paddr == OFS_DIR) begin
			rd = 32'(st.cfg.dir);
		end else if (apb_req.paddr == OFS_STATUS) begin
			rd = {26'h0000000, st.clamped, st.fmt_eff, st.stat};
		end else if (apb_req.paddr == OFS_RELOAD) begin
			rd = 32'h00000000;
		end else begin
			hit = 1'b0;
		end
	end

	// ==========================================================
	// Next-state logic
	always_comb begin
		next_st = st;
		tick = (st.ccnt == CW'(CTRL_CYCLES - 1));
		vmax = torque_mode ? st.cfg.max_tq : st.cfg.max_ps;
		lim = pins.pulse_train ? cmd_speed : 16'(sclamp(17'(cmd_speed), -17'(vmax),
			17'(vmax)));
		dabs = abs33(st.cfg.dev_unit ? 33'(dev_pulse) : 33'(dev_user));
		zs = abs33(33'(act_speed)) <= 33'(st.cfg.zspd);
		zd = dabs <= 33'(st.cfg.dev_range);
		ms_o = (st.opre == PW'(MS_CNT - 1));
		// APB: one wait state, write lands on the edge where pready is seen
		if (apb_req.psel && apb_req.penable && !st.ack) begin
			next_st.ack = 1'b1;
			next_st.prdata = rd;
			next_st.pslverr = !hit;
		end else if (apb_req.psel && apb_req.penable && st.ack) begin
			next_st.ack = 1'b0;
			if (apb_req.pwrite && hit) begin
				if (apb_req.paddr == OFS_COINC) begin
					next_st.cfg.coinc = 16'(uclamp(apb_req.pwdata, MIN_RANGE_SPD, MAX_SPD_CAP));
				end else if (apb_req.paddr == OFS_ZSPD) begin
					next_st.cfg.zspd = 16'(uclamp(apb_req.pwdata, MIN_RANGE_SPD, MAX_SPD_CAP));
				end else if (apb_req.paddr == OFS_DEV_UNIT) begin
					next_st.cfg.dev_unit = apb_req.pwdata[0];
				end else if (apb_req.paddr == OFS_DEV_RANGE) begin
					next_st.cfg.dev_range = 18'(uclamp(apb_req.pwdata, 32'h0, MAX_DEV_RANGE));
				end else if (apb_req.paddr == OFS_FMT) begin
					next_st.cfg.fmt = apb_req.pwdata[0];
				end else if (apb_req.paddr == OFS_MIN_OFF) begin
					next_st.cfg.min_off = 10'(uclamp(apb_req.pwdata, 32'h1, MAX_MS_SET));
				end else if (apb_req.paddr == OFS_JUDGE) begin
					next_st.cfg.judge = 10'(uclamp(apb_req.pwdata, 32'h0, MAX_MS_SET));
				end else if (apb_req.paddr == OFS_MAX_PS) begin
					next_st.cfg.max_ps = 16'(uclamp(apb_req.pwdata, 32'h1, MAX_SPD_CAP));
				end else if (apb_req.paddr == OFS_MAX_TQ) begin
					next_st.cfg.max_tq = 16'(uclamp(apb_req.pwdata, 32'h1, MAX_SPD_CAP));
				end else if (apb_req.paddr == OFS_FWD_TQ) begin
					next_st.cfg.fwd_tq = 9'(uclamp(apb_req.pwdata, 32'h0, MAX_TQ));
				end else if (apb_req.paddr == OFS_REV_TQ) begin
					next_st.cfg.rev_tq = 9'(uclamp(apb_req.pwdata, 32'h0, MAX_TQ));
				end else if (apb_req.paddr == OFS_STROKE) begin
					next_st.cfg.stroke = 15'(uclamp(apb_req.pwdata, 32'h1, MAX_STROKE));
				end else if (apb_req.paddr == OFS_DWELL) begin
					next_st.cfg.dwell = 13'(uclamp(apb_req.pwdata, 32'h0, MAX_DWELL));
				end else if (apb_req.paddr == OFS_DIR) begin
					next_st.cfg.dir = ssmo_dir_e'(2'(uclamp(apb_req.pwdata, 32'h0, MAX_DIR)));
				end else if (apb_req.paddr == OFS_RELOAD) begin
					if (apb_req.pwdata[0]) begin
						next_st.fmt_eff = st.cfg.fmt;
					end
				end
			end
		end
		// Control cycle: all comparisons sampled together
		next_st.ccnt = tick ? '0 : CW'(st.ccnt + 1'b1);
		if (tick) begin
			next_st.clamped = (lim != cmd_speed) || pins.override;
			next_st.stat.speed_match = (pins.fwd_run || pins.rev_run) && (lim == cmd_speed)
				&& !pins.override
				&& (abs33(33'(act_speed) - 33'(lim)) <= 33'(st.cfg.coinc));
			next_st.stat.zero_speed = zs;
			next_st.stat.zero_deviation = zd;
			next_st.cond = zs && zd && (!pins.homing || pins.drained);
			next_st.dev_mon = st.cfg.dev_unit ? dev_pulse : dev_user;
			next_st.spd = lim;
			if (pins.tq_sel == 2'b00) begin
				next_st.tq = 16'(sclamp(17'(torque_cmd), -17'(st.cfg.rev_tq),
					17'(st.cfg.fwd_tq)));
			end else begin
				next_st.tq = torque_cmd;
			end
		end
		// Judgment timer
		next_st.qual_d = st.qual;
		if (!st.cond) begin
			next_st.jcnt = '0;
			next_st.jpre = '0;
			next_st.qual = 1'b0;
		end else if (st.jcnt >= st.cfg.judge) begin
			next_st.qual = 1'b1;
		end else if (st.jpre == PW'(MS_CNT - 1)) begin
			next_st.jpre = '0;
			next_st.jcnt = st.jcnt + 10'h001;
		end else begin
			next_st.jpre = PW'(st.jpre + 1'b1);
		end
		// Output shaping
		next_st.opre = ms_o ? '0 : PW'(st.opre + 1'b1);
		next_st.ocnt = ms_o ? st.ocnt + 10'h001 : st.ocnt;
		case (st.ost)
			SSMO_OUT_IDLE: begin
				next_st.opre = '0;
				next_st.ocnt = '0;
				if (st.qual && (!st.fmt_eff || !st.qual_d)) begin
					next_st.stat.in_position = 1'b1;
					next_st.ost = SSMO_OUT_ON;
				end
			end
			SSMO_OUT_ON: begin
				if (st.fmt_eff) begin
					if (ms_o && (st.ocnt == st.cfg.min_off - 10'h001)) begin
						next_st.stat.in_position = 1'b0;
						next_st.ost = SSMO_OUT_IDLE;
					end
				end else if (!st.qual) begin
					next_st.stat.in_position = 1'b0;
					next_st.opre = '0;
					next_st.ocnt = '0;
					next_st.ost = SSMO_OUT_OFF;
				end else begin
					next_st.opre = '0;
					next_st.ocnt = '0;
				end
			end
			SSMO_OUT_OFF: begin
				if (ms_o && (st.ocnt == st.cfg.min_off - 10'h001)) begin
					next_st.ost = SSMO_OUT_IDLE;
				end
			end
			default: begin
				next_st.ost = SSMO_OUT_IDLE;
			end
		endcase
		// Tuning setting outputs
		next_st.tune.fwd_en = (st.cfg.dir != SSMO_DIR_REV);
		next_st.tune.rev_en = (st.cfg.dir != SSMO_DIR_FWD);
		next_st.tune.stroke = st.cfg.stroke;
		next_st.tune.dwell_ms = st.cfg.dwell;
	end

	// ==========================================================
	// State register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			st <= '0;
			st.cfg.coinc <= 16'(RST_COINC);
			st.cfg.zspd <= 16'(RST_ZSPD);
			st.cfg.dev_range <= 18'(RST_DEV_RANGE);
			st.cfg.min_off <= 10'(RST_MIN_OFF);
			st.cfg.judge <= 10'(RST_JUDGE);
			st.cfg.max_ps <= 16'(RST_MAX_SPD);
			st.cfg.max_tq <= 16'(RST_MAX_SPD);
			st.cfg.fwd_tq <= 9'(RST_TQ);
			st.cfg.rev_tq <= 9'(RST_TQ);
			st.cfg.stroke <= 15'(RST_STROKE);
			st.cfg.dwell <= 13'(RST_DWELL);
			st.cfg.dir <= SSMO_DIR_ALT;
			st.ost <= SSMO_OUT_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Outputs
	assign apb_rsp.pready = st.ack;
	assign apb_rsp.prdata = st.prdata;
	assign apb_rsp.pslverr = st.pslverr;
	assign status = st.stat;
	assign dev_monitor = st.dev_mon;
	assign speed_ref = st.spd;
	assign torque_ref = st.tq;
	assign tune = st.tune;

	// ==========================================================
	// Checking helpers: cycles high, low and condition held
	logic [31:0] hi_cnt;
	logic [31:0] lo_cnt;
	logic [31:0] held_cnt;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			hi_cnt <= 32'h00000000;
			lo_cnt <= 32'hFFFFFFFF;
			held_cnt <= 32'h00000000;
		end else begin
			hi_cnt <= st.stat.in_position ? hi_cnt + 32'h00000001 : 32'h00000000;
			lo_cnt <= st.stat.in_position ? 32'h00000000 :
				((lo_cnt == 32'hFFFFFFFF) ? lo_cnt : lo_cnt + 32'h00000001);
			held_cnt <= st.cond ? held_cnt + 32'h00000001 : 32'h00000000;
		end
	end

	sequence s_tick_run_off;
		tick && !pins.fwd_run && !pins.rev_run;
	endsequence

	chk_match_run_off: assert property (@(posedge mclk) disable iff (!rstn)
		s_tick_run_off |=> !status.speed_match [*2])
		else $error("speed match high with both run inputs off");
	chk_match_clamp: assert property (@(posedge mclk) disable iff (!rstn)
		(tick && (lim != cmd_speed)) |=> !status.speed_match && st.clamped)
		else $error("speed match high while command clipped");
	chk_zero_speed: assert property (@(posedge mclk) disable iff (!rstn)
		tick |=> status.zero_speed == ($past(abs33(33'(act_speed))) <= 33'($past(st.cfg.zspd))))
		else $error("zero speed mismatch");
	chk_inpos_and: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(st.qual) |-> $past(status.zero_speed && status.zero_deviation))
		else $error("in-position qualified without zero speed and deviation");
	chk_homing_drain: assert property (@(posedge mclk) disable iff (!rstn)
		(tick && pins.homing && !pins.drained) |=> !st.cond ##1 !st.qual)
		else $error("in-position condition with pulses pending in homing");
	chk_shot_length: assert property (@(posedge mclk) disable iff (!rstn)
		(st.fmt_eff && $fell(status.in_position))
			|-> $past(hi_cnt) == 32'($past(st.cfg.min_off)) * 32'(MS_CNT) - 32'h00000001)
		else $error("single shot length wrong");
	chk_level_off: assert property (@(posedge mclk) disable iff (!rstn)
		(!st.fmt_eff && $rose(status.in_position))
			|-> $past(lo_cnt) >= 32'(st.cfg.min_off) * 32'(MS_CNT))
		else $error("level output rose inside minimum off time");
	chk_judge_time: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(st.qual) |-> $past(held_cnt) >= 32'($past(st.cfg.judge)) * 32'(MS_CNT))
		else $error("in-position recognised before judgment time");
	chk_torque_lim: assert property (@(posedge mclk) disable iff (!rstn)
		(tick && pins.tq_sel == 2'b00) |=> (torque_ref <= $signed(17'(st.cfg.fwd_tq)))
			&& (torque_ref >= -$signed(17'(st.cfg.rev_tq))))
		else $error("torque outside limits");
	chk_speed_clamp: assert property (@(posedge mclk) disable iff (!rstn)
		(tick && !pins.pulse_train) |=> abs33(33'(speed_ref)) <= 33'($past(vmax)))
		else $error("speed reference above maximum");

endmodule

// file: rtl/ssmo_sync.sv
`timescale 1ns/10ps
module ssmo_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta;

	// ==========================================================
	// Two-stage synchroniser, first stage read only by the second
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end

endmodule
